/* File: logic/fdr_pkg.sv */
// Behaviour
// - mode one: bit 5 shows select bit 0
// - mode one: bit 4 toggles on write-data rise
// - mode one: bit 3 toggles on read-data rise
// - mode two: bit 7 high when no second unit
// - mode two: bits 4,3 complement latched data pins
// - mode two: bit 2 complements latched write gate
// - mode two: bit 1 low while drive D selected
// - mode two: bit 0 low while drive C selected
// - digital output register is write-only control
// - master reset pin clears digital output register
// - normal mode: tape register holds bits 1:0 only
// - three-mode: bits 7:6 mirror media bits 3:2
// - three-mode: bits 5:4 mirror selected drive type
// - three-mode: bits 3:2 mirror boot bits 1:0
// - tape select 00 none, else drives 1-3
// - index 4 reads main status, writes rate
// - rate follows last rate or config write
// - rate register bit 7 pulses software reset
// - rate register bit 6 selects power-down
// - rate register bits 4:2 select precompensation
package fdr_pkg;
  // register indices; byte address is four times the index
  localparam logic [3:0] FDR_IDX_STATUS_B = 4'h1;
  localparam logic [3:0] FDR_IDX_DIG_OUT = 4'h2;
  localparam logic [3:0] FDR_IDX_TAPE = 4'h3;
  localparam logic [3:0] FDR_IDX_MAIN_RATE = 4'h4;
  localparam logic [3:0] FDR_IDX_CFG_CTL = 4'h7;
  localparam logic [3:0] FDR_IDX_OPTIONS = 4'h8;
  localparam logic [3:0] FDR_IDX_DRIVE_TYPE = 4'h9;
  localparam logic [3:0] FDR_IDX_MEDIA_BOOT = 4'ha;
  // digital output register fields
  localparam int FDR_DOR_SEL_LO = 0;
  localparam int FDR_DOR_RUN_BIT = 2;
  localparam int FDR_DOR_REQ_EN_BIT = 3;
  localparam int FDR_DOR_MOT_LO = 4;
  localparam logic [7:0] FDR_DOR_RESET = 8'h00;
  // drive select codes
  localparam logic [1:0] FDR_DRV_A = 2'h0;
  localparam logic [1:0] FDR_DRV_B = 2'h1;
  localparam logic [1:0] FDR_DRV_C = 2'h2;
  localparam logic [1:0] FDR_DRV_D = 2'h3;
  // status b bit positions
  localparam int FDR_SB_MOT_A = 0;
  localparam int FDR_SB_MOT_B = 1;
  localparam int FDR_SB_DSC = 0;
  localparam int FDR_SB_DSD = 1;
  localparam int FDR_SB_WGATE = 2;
  localparam int FDR_SB_RDATA = 3;
  localparam int FDR_SB_WDATA = 4;
  localparam int FDR_SB_SEL0 = 5;
  localparam int FDR_SB_DSA = 5;
  localparam int FDR_SB_DSB = 6;
  localparam int FDR_SB_SECOND_UNIT_ABSENT = 7;
  // rate register fields
  localparam int FDR_DR_SWRST_BIT = 7;
  localparam int FDR_DR_PWRDN_BIT = 6;
  localparam int FDR_DR_PRECOMP_LO = 2;
  localparam int FDR_RATE_LO = 0;
  // tape register fields
  localparam int FDR_TD_MEDIA_LO = 6;
  localparam int FDR_TD_TYPE_LO = 4;
  localparam int FDR_TD_BOOT_LO = 2;
  localparam int FDR_TD_SEL_LO = 0;
  localparam int FDR_MB_MEDIA_LO = 2;
  localparam int FDR_MB_BOOT_LO = 0;
  // option register bits
  localparam int FDR_OPT_MODE_BIT = 0;
  localparam int FDR_OPT_3MODE_BIT = 1;
  localparam int FDR_OPT_NO2ND_BIT = 2;
  localparam logic [2:0] FDR_OPT_RESET = 3'h0;
  localparam logic [7:0] FDR_RD_ZERO = 8'h00;
  typedef enum logic {FDR_MODE_ONE, FDR_MODE_TWO} fdr_mode_e;
endpackage

/* File: logic/fdr_pin_track.sv */
// follows one drive pin: toggles and sets a latch on each rising edge
module fdr_pin_track
  import fdr_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic pin_in,
  input wire logic clear_in,
  output logic toggle_out,
  output logic latch_out
);
  typedef struct packed {
    logic prev;
    logic toggle;
    logic latch;
  } fdr_track_s;
  fdr_track_s st_r;
  fdr_track_s st_nxt;
  logic rise;

  // a rise in the clearing cycle still sets the latch
  always_comb
  begin
    st_nxt = st_r;
    rise = pin_in & ~st_r.prev;
    st_nxt.prev = pin_in;
    st_nxt.toggle = st_r.toggle ^ rise;
    if (rise)
      st_nxt.latch = 1'b1;
    else if (clear_in)
      st_nxt.latch = 1'b0;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign toggle_out = st_r.toggle;
  assign latch_out = st_r.latch;
endmodule

/* File: logic/fdr_bus_port.sv */
// classic wishbone handshake: one wait state, ack for exactly one cycle
module fdr_bus_port
  import fdr_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic cyc_in,
  input wire logic stb_in,
  input wire logic we_in,
  input wire logic sel0_in,
  output logic ack_out,
  output logic rd_take_out,
  output logic wr_commit_out
);
  typedef struct packed {
    logic ack;
  } fdr_port_s;
  fdr_port_s st_r;
  fdr_port_s st_nxt;
  logic req;

  // ack drops after one cycle so a held request is not answered twice
  always_comb
  begin
    req = cyc_in & stb_in;
    st_nxt.ack = req & ~st_r.ack;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // reads load data when taken, writes land on the acked edge
  assign rd_take_out = cyc_in & stb_in & ~we_in & ~st_r.ack;
  assign wr_commit_out = cyc_in & stb_in & we_in & sel0_in & st_r.ack;
  assign ack_out = st_r.ack;
endmodule

/* File: logic/fdr_regs.sv */
// host-side status and control registers of the floppy controller
//
// Chosen here: register access over Wishbone.
module fdr_regs
  import fdr_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [5:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic master_reset_pin_in,
  input wire logic write_data_pin_in,
  input wire logic read_data_pin_in,
  input wire logic write_gate_pin_in,
  input wire logic [7:0] main_status_in,
  output logic [1:0] drive_select_out,
  output logic [3:0] motor_enable_out,
  output logic req_irq_enable_out,
  output logic fdc_reset_out,
  output logic soft_reset_out,
  output logic power_down_out,
  output logic [2:0] write_shift_select_out,
  output logic [1:0] rate_sel_out,
  output logic [1:0] tape_unit_out
);
  typedef struct packed {
    logic [7:0] dor;
    logic [1:0] tape_sel;
    logic pwr_down;
    logic [2:0] precomp;
    logic [1:0] rate;
    logic [2:0] opt;
    logic [7:0] drive_type;
    logic [3:0] media_boot;
    logic soft_rst;
    logic fdc_rst;
    logic [7:0] rdata;
  } fdr_regs_s;
  fdr_regs_s st_r;
  fdr_regs_s st_nxt;

  logic rd_take;
  logic wr_commit;
  logic [3:0] idx;
  logic [7:0] wbyte;
  logic wd_tog, wd_lat, rd_tog, rd_lat, wg_tog, wg_lat;
  logic sb_clear;
  fdr_mode_e mode;
  logic three_mode;
  logic [1:0] sel;
  logic [7:0] status_b;
  logic [7:0] tape_byte;
  logic [7:0] rd_mux;

  fdr_bus_port u_port (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .cyc_in(wb_cyc_in),
    .stb_in(wb_stb_in),
    .we_in(wb_we_in),
    .sel0_in(wb_sel_in[0]),
    .ack_out(wb_ack_out),
    .rd_take_out(rd_take),
    .wr_commit_out(wr_commit)
  );

  // reading status b consumes the mode-two latches
  assign sb_clear = rd_take & (idx == FDR_IDX_STATUS_B);

  fdr_pin_track u_wd (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .pin_in(write_data_pin_in),
    .clear_in(sb_clear),
    .toggle_out(wd_tog),
    .latch_out(wd_lat)
  );

  fdr_pin_track u_rd (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .pin_in(read_data_pin_in),
    .clear_in(sb_clear),
    .toggle_out(rd_tog),
    .latch_out(rd_lat)
  );

  fdr_pin_track u_wg (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .pin_in(write_gate_pin_in),
    .clear_in(sb_clear),
    .toggle_out(wg_tog),
    .latch_out(wg_lat)
  );

  // decode helpers; only the low byte lane carries data
  assign idx = wb_adr_in[5:2];
  assign wbyte = wb_dat_in[7:0];
  assign mode = st_r.opt[FDR_OPT_MODE_BIT] ? FDR_MODE_TWO : FDR_MODE_ONE;
  assign three_mode = st_r.opt[FDR_OPT_3MODE_BIT];
  assign sel = st_r.dor[FDR_DOR_SEL_LO +: 2];

  // status b view depends on the compatibility mode
  always_comb
  begin
    status_b = FDR_RD_ZERO;
    case (mode)
      FDR_MODE_ONE:
      begin
        status_b[FDR_SB_SEL0] = st_r.dor[FDR_DOR_SEL_LO];
        status_b[FDR_SB_WDATA] = wd_tog;
        status_b[FDR_SB_RDATA] = rd_tog;
        status_b[FDR_SB_WGATE] = write_gate_pin_in;
        status_b[FDR_SB_MOT_B] = st_r.dor[FDR_DOR_MOT_LO + 1];
        status_b[FDR_SB_MOT_A] = st_r.dor[FDR_DOR_MOT_LO];
      end
      FDR_MODE_TWO:
      begin
        status_b[FDR_SB_SECOND_UNIT_ABSENT] = st_r.opt[FDR_OPT_NO2ND_BIT];
        status_b[FDR_SB_DSB] = (sel != FDR_DRV_B);
        status_b[FDR_SB_DSA] = (sel != FDR_DRV_A);
        status_b[FDR_SB_WDATA] = ~wd_lat;
        status_b[FDR_SB_RDATA] = ~rd_lat;
        status_b[FDR_SB_WGATE] = ~wg_lat;
        status_b[FDR_SB_DSD] = (sel != FDR_DRV_D);
        status_b[FDR_SB_DSC] = (sel != FDR_DRV_C);
      end
      default:
        status_b = FDR_RD_ZERO;
    endcase
  end

  // tape register; upper fields appear only in three-mode
  always_comb
  begin
    tape_byte = FDR_RD_ZERO;
    tape_byte[FDR_TD_SEL_LO +: 2] = st_r.tape_sel;
    if (three_mode)
    begin
      tape_byte[FDR_TD_MEDIA_LO +: 2] = st_r.media_boot[FDR_MB_MEDIA_LO +: 2];
      tape_byte[FDR_TD_TYPE_LO +: 2] = st_r.drive_type[{sel, 1'b0} +: 2];
      tape_byte[FDR_TD_BOOT_LO +: 2] = st_r.media_boot[FDR_MB_BOOT_LO +: 2];
    end
  end

  // read mux; digital output and rate registers are write-only
  always_comb
  begin
    case (idx)
      FDR_IDX_STATUS_B: rd_mux = status_b;
      FDR_IDX_TAPE: rd_mux = tape_byte;
      FDR_IDX_MAIN_RATE: rd_mux = main_status_in;
      FDR_IDX_OPTIONS: rd_mux = {5'h00, st_r.opt};
      FDR_IDX_DRIVE_TYPE: rd_mux = st_r.drive_type;
      FDR_IDX_MEDIA_BOOT: rd_mux = {4'h0, st_r.media_boot};
      default: rd_mux = FDR_RD_ZERO;
    endcase
  end

  // register writes, software reset pulse and master reset
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.soft_rst = 1'b0;
    if (rd_take)
      st_nxt.rdata = rd_mux;
    if (wr_commit)
    begin
      case (idx)
        FDR_IDX_DIG_OUT: st_nxt.dor = wbyte;
        FDR_IDX_TAPE: st_nxt.tape_sel = wbyte[FDR_TD_SEL_LO +: 2];
        FDR_IDX_MAIN_RATE:
        begin
          st_nxt.soft_rst = wbyte[FDR_DR_SWRST_BIT];
          st_nxt.pwr_down = wbyte[FDR_DR_PWRDN_BIT];
          st_nxt.precomp = wbyte[FDR_DR_PRECOMP_LO +: 3];
          st_nxt.rate = wbyte[FDR_RATE_LO +: 2];
        end
        FDR_IDX_CFG_CTL: st_nxt.rate = wbyte[FDR_RATE_LO +: 2];
        FDR_IDX_OPTIONS: st_nxt.opt = wbyte[2:0];
        FDR_IDX_DRIVE_TYPE: st_nxt.drive_type = wbyte;
        FDR_IDX_MEDIA_BOOT: st_nxt.media_boot = wbyte[3:0];
        default: st_nxt.rdata = st_nxt.rdata;
      endcase
    end
    // the pin wins over a write landing in the same cycle
    if (master_reset_pin_in)
      st_nxt.dor = FDR_DOR_RESET;
    st_nxt.fdc_rst = ~st_nxt.dor[FDR_DOR_RUN_BIT] | st_nxt.soft_rst;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      st_r <= '0;
      st_r.dor <= FDR_DOR_RESET;
      st_r.opt <= FDR_OPT_RESET;
      st_r.fdc_rst <= 1'b1; // cleared register means controller held in reset
    end
    else
      st_r <= st_nxt;
  end

  // outputs all come from the state register
  assign wb_dat_out = {24'h000000, st_r.rdata};
  assign drive_select_out = st_r.dor[FDR_DOR_SEL_LO +: 2];
  assign motor_enable_out = st_r.dor[FDR_DOR_MOT_LO +: 4];
  assign req_irq_enable_out = st_r.dor[FDR_DOR_REQ_EN_BIT];
  assign fdc_reset_out = st_r.fdc_rst;
  assign soft_reset_out = st_r.soft_rst;
  assign power_down_out = st_r.pwr_down;
  assign write_shift_select_out = st_r.precomp;
  assign rate_sel_out = st_r.rate;
  assign tape_unit_out = st_r.tape_sel;

  // checks on register behaviour
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (reset_in);

  logic wr_dr, wr_cc, rd_sb, rd_td;
  assign wr_dr = wr_commit & (idx == FDR_IDX_MAIN_RATE);
  assign wr_cc = wr_commit & (idx == FDR_IDX_CFG_CTL);
  assign rd_sb = rd_take & (idx == FDR_IDX_STATUS_B);
  assign rd_td = rd_take & (idx == FDR_IDX_TAPE);

  a_dor_mr_clear: assert property (master_reset_pin_in |=> st_r.dor == FDR_DOR_RESET)
    else $error("master reset left the digital output register set");
  a_sb_sel_one: assert property ((rd_sb && mode == FDR_MODE_ONE)
    |=> wb_dat_out[FDR_SB_SEL0] == $past(st_r.dor[FDR_DOR_SEL_LO]))
    else $error("status b select bit does not follow the output register");
  a_wd_toggle: assert property ($rose(write_data_pin_in) |=> wd_tog != $past(wd_tog))
    else $error("write data toggle missed a rising edge");
  a_rd_toggle: assert property ($rose(read_data_pin_in) |=> rd_tog != $past(rd_tog))
    else $error("read data toggle missed a rising edge");
  a_sb_second_unit_absent_two: assert property ((rd_sb && mode == FDR_MODE_TWO)
    |=> wb_dat_out[FDR_SB_SECOND_UNIT_ABSENT] == $past(st_r.opt[FDR_OPT_NO2ND_BIT]))
    else $error("status b second unit bit wrong");
  a_sb_dsd_two: assert property ((rd_sb && mode == FDR_MODE_TWO && sel == FDR_DRV_D)
    |=> !wb_dat_out[FDR_SB_DSD] && wb_dat_out[FDR_SB_DSC])
    else $error("status b drive d flag wrong");
  a_td_hidden: assert property ((rd_td && !three_mode) |=> wb_dat_out[7:2] == 6'h00)
    else $error("tape register upper bits visible outside three-mode");
  a_td_media: assert property ((rd_td && three_mode) |=> wb_dat_out[7:6]
    == $past(st_r.media_boot[FDR_MB_MEDIA_LO +: 2]))
    else $error("tape register media bits do not mirror configuration");
  a_sw_reset: assert property ((wr_dr && wbyte[FDR_DR_SWRST_BIT])
    |=> soft_reset_out && fdc_reset_out ##1 !soft_reset_out)
    else $error("software reset pulse missing or too long");
  a_rate_last: assert property ((wr_cc || wr_dr) |=> rate_sel_out == $past(wbyte[1:0]))
    else $error("rate does not follow the last rate write");
  a_pwr_down: assert property (wr_dr |=> power_down_out == $past(wbyte[FDR_DR_PWRDN_BIT]))
    else $error("power-down bit not taken from rate write");

  // mode-one status b view of the toggles, read back through the bus
  a_sb_wd_one: assert property ((rd_sb && mode == FDR_MODE_ONE)
    |=> wb_dat_out[FDR_SB_WDATA] == $past(wd_tog))
    else $error("status b write data toggle not returned");
  a_sb_rd_one: assert property ((rd_sb && mode == FDR_MODE_ONE)
    |=> wb_dat_out[FDR_SB_RDATA] == $past(rd_tog))
    else $error("status b read data toggle not returned");

  // mode-two latches: set by a pin rise, shown inverted on a read; then the drive c flag
  a_wd_latch_set: assert property ($rose(write_data_pin_in) |=> wd_lat)
    else $error("write data latch missed a rising edge");
  a_wg_latch_set: assert property ($rose(write_gate_pin_in) |=> wg_lat)
    else $error("write gate latch missed a rising edge");
  a_sb_wdata_two: assert property ((rd_sb && mode == FDR_MODE_TWO)
    |=> wb_dat_out[FDR_SB_WDATA] == !$past(wd_lat))
    else $error("status b write data latch not inverted");
  a_sb_rdata_two: assert property ((rd_sb && mode == FDR_MODE_TWO)
    |=> wb_dat_out[FDR_SB_RDATA] == !$past(rd_lat))
    else $error("status b read data latch not inverted");
  a_sb_wgate_two: assert property ((rd_sb && mode == FDR_MODE_TWO)
    |=> wb_dat_out[FDR_SB_WGATE] == !$past(wg_lat))
    else $error("status b write gate latch not inverted");
  a_sb_dsc_two: assert property ((rd_sb && mode == FDR_MODE_TWO && sel == FDR_DRV_C)
    |=> !wb_dat_out[FDR_SB_DSC] && wb_dat_out[FDR_SB_DSD])
    else $error("status b drive c flag wrong");

  // tape register fields seen on reads, and the tape unit taken from a write
  a_td_select: assert property (rd_td
    |=> wb_dat_out[FDR_TD_SEL_LO +: 2] == $past(st_r.tape_sel))
    else $error("tape register select bits not returned");
  a_td_type: assert property ((rd_td && three_mode)
    |=> wb_dat_out[FDR_TD_TYPE_LO +: 2] == $past(st_r.drive_type[2 * sel +: 2]))
    else $error("tape register drive type does not follow selection");
  a_td_boot: assert property ((rd_td && three_mode)
    |=> wb_dat_out[FDR_TD_BOOT_LO +: 2] == $past(st_r.media_boot[FDR_MB_BOOT_LO +: 2]))
    else $error("tape register boot bits do not mirror configuration");
  a_tape_write: assert property ((wr_commit && idx == FDR_IDX_TAPE)
    |=> tape_unit_out == $past(wbyte[FDR_TD_SEL_LO +: 2]))
    else $error("tape unit not taken from write");

  // shared index four and the write-only output register
  a_main_status: assert property ((rd_take && idx == FDR_IDX_MAIN_RATE)
    |=> wb_dat_out[7:0] == $past(main_status_in))
    else $error("index four read does not return main status");
  a_precomp_take: assert property (wr_dr
    |=> write_shift_select_out == $past(wbyte[FDR_DR_PRECOMP_LO +: 3]))
    else $error("precompensation select not taken from rate write");
  a_dor_hidden: assert property ((rd_take && idx == FDR_IDX_DIG_OUT)
    |=> wb_dat_out[7:0] == FDR_RD_ZERO)
    else $error("digital output register readable");
  a_dor_write: assert property ((wr_commit && idx == FDR_IDX_DIG_OUT && !master_reset_pin_in)
    |=> st_r.dor == $past(wbyte))
    else $error("digital output register write lost");

  // bus handshake and controller reset output
  a_ack_single: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack held longer than one cycle");
  a_fdc_run: assert property (!soft_reset_out |-> fdc_reset_out == !st_r.dor[FDR_DOR_RUN_BIT])
    else $error("controller reset does not follow the run bit");

  c_sb_mode_two: cover property (rd_sb && mode == FDR_MODE_TWO && wd_lat);
  c_td_three: cover property (rd_td && three_mode);
  c_soft_reset: cover property (wr_dr && wbyte[FDR_DR_SWRST_BIT]);
  c_cc_after_dr: cover property (wr_dr ##[1:20] wr_cc);
  c_mr_clear: cover property (master_reset_pin_in && st_r.dor != FDR_DOR_RESET);
endmodule

/* File: tb/fdr_host_model.sv */
// host processor model: classic wishbone single cycles, one at a time
module fdr_host_model
  import fdr_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic wb_ack_in,
  input wire logic [31:0] wb_dat_in,
  output logic wb_cyc_out,
  output logic wb_stb_out,
  output logic wb_we_out,
  output logic [5:0] wb_adr_out,
  output logic [3:0] wb_sel_out,
  output logic [31:0] wb_dat_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int hang_count = 0;

  // idle bus from time zero
  initial
  begin
    wb_cyc_out = 1'b0;
    wb_stb_out = 1'b0;
    wb_we_out = 1'b0;
    wb_adr_out = 6'h00;
    wb_sel_out = 4'h0;
    wb_dat_out = 32'h0;
  end

  // request held until ack is seen at a rising edge; bounded so a dead slave cannot hang us
  task automatic xfer(input logic w, input logic [3:0] idx, input logic [7:0] wd,
                      output logic [7:0] rd);
    int n;
    @(posedge clk_sys_in);
    wb_cyc_out <= 1'b1;
    wb_stb_out <= 1'b1;
    wb_we_out <= w;
    wb_adr_out <= {idx, 2'h0};
    wb_sel_out <= 4'h1;
    wb_dat_out <= {24'h0, wd};
    n = 0;
    do
    begin
      @(posedge clk_sys_in);
      n++;
    end
    while (wb_ack_in !== 1'b1 && n < 16);
    if (wb_ack_in !== 1'b1)
      hang_count++;
    rd = wb_dat_in[7:0];
    wb_cyc_out <= 1'b0;
    wb_stb_out <= 1'b0;
    wb_we_out <= 1'b0;
  endtask
endmodule

/* File: tb/fdr_regs_test.sv */
module fdr_regs_test
  import fdr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_in = 1'b0;
  logic reset_in = 1'b1;
  logic mr_pin = 1'b0;
  logic [2:0] pins = 3'h0; // write data, read data, write gate
  logic [7:0] ms = 8'h5a;
  logic cyc, stb, we, ack, req, frst, srst, pdn;
  logic [5:0] adr;
  logic [3:0] sel, mot;
  logic [31:0] dat_w, dat_r;
  logic [1:0] dsel, rsel, tunit;
  logic [2:0] shift;
  logic [7:0] v, dview, rview;
  int errors = 0;
  int cmp_count = 0;

  // packed views of the control outputs, compared as one byte
  assign dview = {mot, req, frst, dsel};
  assign rview = {srst, pdn, 1'b0, shift, rsel};

  always #25 clk_sys_in = ~clk_sys_in;

  fdr_regs fdr_regs_inst (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dat_w),
    .wb_dat_out(dat_r), .wb_ack_out(ack), .master_reset_pin_in(mr_pin),
    .write_data_pin_in(pins[0]), .read_data_pin_in(pins[1]), .write_gate_pin_in(pins[2]),
    .main_status_in(ms), .drive_select_out(dsel), .motor_enable_out(mot),
    .req_irq_enable_out(req), .fdc_reset_out(frst), .soft_reset_out(srst),
    .power_down_out(pdn), .write_shift_select_out(shift), .rate_sel_out(rsel),
    .tape_unit_out(tunit));

  fdr_host_model fdr_host_model_inst (.clk_sys_in(clk_sys_in), .wb_ack_in(ack),
    .wb_dat_in(dat_r), .wb_cyc_out(cyc), .wb_stb_out(stb), .wb_we_out(we),
    .wb_adr_out(adr), .wb_sel_out(sel), .wb_dat_out(dat_w));

  task automatic finish_test();
    errors += fdr_host_model_inst.hang_count;
    if (errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // one bus access; a lost ack ends the run at once
  task automatic acc(input logic w, input logic [3:0] idx, input logic [7:0] d);
    fdr_host_model_inst.xfer(w, idx, d, v);
    if (fdr_host_model_inst.hang_count != 0)
      finish_test();
  endtask

  task automatic chk_out(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_reg(input logic [3:0] idx, input logic [7:0] exp);
    acc(1'b0, idx, 8'h00);
    chk_out($sformatf("reg %h", idx), exp, v);
  endtask

  // pins held two cycles so the edge detector sees each level
  task automatic pulse(input logic [2:0] m);
    @(posedge clk_sys_in);
    pins <= m;
    repeat (2) @(posedge clk_sys_in);
    pins <= 3'h0;
    repeat (2) @(posedge clk_sys_in);
  endtask

  // outputs sampled mid-cycle, after the launching edge has settled
  initial
  begin
    repeat (4) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    @(negedge clk_sys_in);
    chk_out("dor outputs", 8'h04, dview);
    chk_reg(4'h3, 8'h00);
    chk_reg(4'hf, 8'h00);
    acc(1'b1, 4'h2, 8'hfd);
    @(negedge clk_sys_in);
    chk_out("dor outputs", 8'hf9, dview);
    chk_reg(4'h2, 8'h00);
    pulse(3'h1);
    pulse(3'h2);
    pulse(3'h2);
    acc(1'b0, 4'h1, 8'h00);
    chk_out("status b", 8'h33, v & 8'h3f);
    pulse(3'h2);
    acc(1'b0, 4'h1, 8'h00);
    chk_out("status b", 8'h3b, v & 8'h3f);
    // second mode; first read only clears the latches
    acc(1'b1, 4'h8, 8'h05);
    acc(1'b0, 4'h1, 8'h00);
    chk_reg(4'h1, 8'hbf);
    pulse(3'h5);
    chk_reg(4'h1, 8'hab);
    chk_reg(4'h1, 8'hbf);
    acc(1'b1, 4'h2, 8'hfe);
    chk_reg(4'h1, 8'hfe);
    acc(1'b1, 4'h2, 8'hff);
    chk_reg(4'h1, 8'hfd);
    acc(1'b1, 4'h8, 8'h01);
    chk_reg(4'h1, 8'h7d);
    for (int i = 0; i < 4; i++)
    begin
      acc(1'b1, 4'h3, 8'hfc | 8'(i));
      chk_reg(4'h3, 8'(i));
      chk_out("tape unit", 8'(i), {6'h0, tunit});
    end
    acc(1'b1, 4'h9, 8'he4);
    acc(1'b1, 4'ha, 8'h0b);
    acc(1'b1, 4'h8, 8'h02);
    chk_reg(4'h3, 8'hbf);
    acc(1'b1, 4'h2, 8'hfe);
    chk_reg(4'h3, 8'haf);
    @(posedge clk_sys_in);
    mr_pin <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    mr_pin <= 1'b0;
    @(negedge clk_sys_in);
    chk_out("dor outputs", 8'h04, dview);
    chk_reg(4'h4, 8'h5a);
    acc(1'b1, 4'h4, 8'h9e);
    @(negedge clk_sys_in);
    chk_out("rate outputs", 8'h9e, rview);
    @(negedge clk_sys_in);
    chk_out("rate outputs", 8'h1e, rview);
    acc(1'b1, 4'h7, 8'h01);
    @(negedge clk_sys_in);
    chk_out("rate outputs", 8'h1d, rview);
    acc(1'b1, 4'h4, 8'h4b);
    @(negedge clk_sys_in);
    chk_out("rate outputs", 8'h4b, rview);
    finish_test();
  end
endmodule
